//--- lpsc_defines.svh
`ifndef LPSC_DEFINES_SVH
`define LPSC_DEFINES_SVH

// synchroniser depth for the request pins
`define LPSC_SYNC_STAGES 2
// index of each request in the synchronised vector
`define LPSC_REQ_STOP    0
`define LPSC_REQ_SLEEP   1
`define LPSC_REQ_DEEP    2
`define LPSC_REQ_COUNT   3
// reset value of each gate: clocks run, recognition enabled
`define LPSC_GATE_RESET  1'h1
`define LPSC_ACK_RESET   1'h0
`define LPSC_SYNC_RESET  1'h1

`endif

//--- lpsc_pkg.sv
`default_nettype none
package lpsc_pkg;
	// gray codes along run -> grant -> sleep -> deep
	typedef enum logic [1:0] {
		LPSC_RUN   = 2'h0,
		LPSC_GRANT = 2'h1,
		LPSC_SLEEP = 2'h3,
		LPSC_DEEP  = 2'h2
	} lpsc_state_e;
endpackage
`default_nettype wire

//--- lpsc_sync.sv
`timescale 1ns/1ps
`default_nettype none
`include "lpsc_defines.svh"

module lpsc_sync
(
	input  wire logic       mclk,
	input  wire logic       nrst,
	input  wire logic       clkEn,
	input  wire logic       asyncIn,
	output logic            syncOut
);
	logic stage1_q;
	logic stage2_q;
	logic stage1_d;
	logic stage2_d;

	always_comb
	begin
		stage1_d = clkEn ? asyncIn : stage1_q;
		stage2_d = clkEn ? stage1_q : stage2_q;
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			stage1_q <= `LPSC_SYNC_RESET;
			stage2_q <= `LPSC_SYNC_RESET;
		end
		else
		begin
			stage1_q <= stage1_d;
			stage2_q <= stage2_d;
		end
	end

	assign syncOut = stage2_q;
endmodule
`default_nettype wire

//--- low_power_state_controller.sv
// Overview of operation
// - sleep request in stop grant moves the controller to sleep.
// - sleep gates every unit clock; only the PLL keeps running.
// - sleep ignores snoops and interrupt requests.
// - sleep reacts only to reset, sleep release, deep-sleep request.
// - sleep release returns to stop grant and restarts bus and interrupt controller clocks; core clock stays stopped.
// - deep-sleep request while sleeping moves to deep sleep.
// - clock-stop request enters stop grant and issues an acknowledge transaction.
// - stop grant stops core clocks; bus unit and interrupt controller keep clocks.
// - stop grant keeps snooping and servicing interrupts.
// - clock-stop release restarts all clocks and resumes execution.
// - clock-stop request is asynchronous and never touches the bus clock.
`timescale 1ns/1ps
`default_nettype none
`include "lpsc_defines.svh"

module low_power_state_controller
	import lpsc_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       nrst,
	input  wire logic       clkEn,
	input  wire logic       clock_stop_request_n,
	input  wire logic       sleep_request_n,
	input  wire logic       deep_sleep_request_n,
	input  wire logic       busClkPresent,
	output logic            coreClkEn,
	output logic            busClkEn,
	output logic            intCtrlClkEn,
	output logic            pllEn,
	output logic            snoopEn,
	output logic            intrEn,
	output logic            stopGrantAck,
	output logic [1:0]      powerState
);
	logic [`LPSC_REQ_COUNT-1:0] reqRaw;
	logic [`LPSC_REQ_COUNT-1:0] reqSyncN;

	assign reqRaw[`LPSC_REQ_STOP]  = clock_stop_request_n;
	assign reqRaw[`LPSC_REQ_SLEEP] = sleep_request_n;
	assign reqRaw[`LPSC_REQ_DEEP]  = deep_sleep_request_n;

	// requests come from the chipset with no relation to mclk
	genvar gi;
	generate
		for (gi = 0; gi < `LPSC_REQ_COUNT; gi++)
		begin : g_sync
			lpsc_sync u_sync
			(
				.mclk    (mclk),
				.nrst    (nrst),
				.clkEn   (clkEn),
				.asyncIn (reqRaw[gi]),
				.syncOut (reqSyncN[gi])
			);
		end
	endgenerate

	logic stopReq;
	logic sleepReq;
	logic deepReq;
	assign stopReq  = !reqSyncN[`LPSC_REQ_STOP];
	assign sleepReq = !reqSyncN[`LPSC_REQ_SLEEP];
	assign deepReq  = !reqSyncN[`LPSC_REQ_DEEP];

	lpsc_state_e state_q;
	lpsc_state_e state_d;
	logic        ack_q;
	logic        ack_d;
	logic        core_q, core_d;
	logic        bus_q, bus_d;
	logic        intc_q, intc_d;
	logic        pll_q, pll_d;
	logic        snoop_q, snoop_d;
	logic        intr_q, intr_d;

	always_comb
	begin
		state_d = state_q;
		ack_d   = 1'h0;
		case (state_q)
			LPSC_RUN:
				if (stopReq)
				begin
					state_d = LPSC_GRANT;
					ack_d   = 1'h1;
				end
			LPSC_GRANT:
				if (sleepReq)
					state_d = LPSC_SLEEP;
				else if (!stopReq)
					state_d = LPSC_RUN;
			LPSC_SLEEP:
				// only sleep release and deep request matter here; reset and
				// clock loss act on the flops themselves
				if (!sleepReq)
					state_d = LPSC_GRANT;
				else if (deepReq)
					state_d = LPSC_DEEP;
			LPSC_DEEP:
				// bus clock back and deep released: fall back to sleep
				if (!deepReq && busClkPresent)
					state_d = LPSC_SLEEP;
			default:
				state_d = LPSC_RUN;
		endcase
		if (!clkEn)
		begin
			state_d = state_q;
			ack_d   = ack_q;
		end
	end

	// gates follow the next state so they switch with the state register
	always_comb
	begin
		core_d  = 1'h1;
		bus_d   = 1'h1;
		intc_d  = 1'h1;
		pll_d   = 1'h1;
		snoop_d = 1'h1;
		intr_d  = 1'h1;
		case (state_d)
			LPSC_RUN:
			begin
				core_d = 1'h1;
			end
			LPSC_GRANT:
				core_d = 1'h0;
			LPSC_SLEEP:
			begin
				core_d  = 1'h0;
				bus_d   = 1'h0;
				intc_d  = 1'h0;
				snoop_d = 1'h0;
				intr_d  = 1'h0;
			end
			LPSC_DEEP:
			begin
				core_d  = 1'h0;
				bus_d   = 1'h0;
				intc_d  = 1'h0;
				pll_d   = 1'h0;
				snoop_d = 1'h0;
				intr_d  = 1'h0;
			end
			default:
				core_d = 1'h1;
		endcase
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_q <= LPSC_RUN;
			ack_q   <= `LPSC_ACK_RESET;
			core_q  <= `LPSC_GATE_RESET;
			bus_q   <= `LPSC_GATE_RESET;
			intc_q  <= `LPSC_GATE_RESET;
			pll_q   <= `LPSC_GATE_RESET;
			snoop_q <= `LPSC_GATE_RESET;
			intr_q  <= `LPSC_GATE_RESET;
		end
		else
		begin
			state_q <= state_d;
			ack_q   <= ack_d;
			core_q  <= core_d;
			bus_q   <= bus_d;
			intc_q  <= intc_d;
			pll_q   <= pll_d;
			snoop_q <= snoop_d;
			intr_q  <= intr_d;
		end
	end

	assign coreClkEn    = core_q;
	assign busClkEn     = bus_q;
	assign intCtrlClkEn = intc_q;
	assign pllEn        = pll_q;
	assign snoopEn      = snoop_q;
	assign intrEn       = intr_q;
	assign stopGrantAck = ack_q;
	assign powerState   = state_q;

	sequence s_enterGrant;
		state_q == LPSC_RUN && stopReq && clkEn;
	endsequence

	property p_sleepEntry;
		@(posedge mclk) disable iff (!nrst)
		state_q == LPSC_GRANT && sleepReq && clkEn |=> state_q == LPSC_SLEEP;
	endproperty
	a_sleepEntry: assert property (p_sleepEntry) else $error("no sleep entry");

	property p_sleepGates;
		@(posedge mclk) disable iff (!nrst)
		state_q == LPSC_SLEEP |-> !coreClkEn && !busClkEn && !intCtrlClkEn && pllEn;
	endproperty
	a_sleepGates: assert property (p_sleepGates) else $error("sleep gates wrong");

	property p_sleepDeaf;
		@(posedge mclk) disable iff (!nrst)
		state_q == LPSC_SLEEP |-> !snoopEn && !intrEn;
	endproperty
	a_sleepDeaf: assert property (p_sleepDeaf) else $error("sleep recognises events");

	property p_sleepHold;
		@(posedge mclk) disable iff (!nrst)
		state_q == LPSC_SLEEP && sleepReq && !deepReq |=> state_q == LPSC_SLEEP;
	endproperty
	a_sleepHold: assert property (p_sleepHold) else $error("sleep left early");

	property p_sleepExit;
		@(posedge mclk) disable iff (!nrst)
		state_q == LPSC_SLEEP && !sleepReq && clkEn |=> state_q == LPSC_GRANT && busClkEn;
	endproperty
	a_sleepExit: assert property (p_sleepExit) else $error("sleep exit wrong");

	property p_deepEntry;
		@(posedge mclk) disable iff (!nrst)
		state_q == LPSC_SLEEP && sleepReq && deepReq && clkEn |=> state_q == LPSC_DEEP;
	endproperty
	a_deepEntry: assert property (p_deepEntry) else $error("no deep entry");

	property p_grantAck;
		@(posedge mclk) disable iff (!nrst)
		// a frozen clock holds the pulse, so only an enabled cycle must drop it
		s_enterGrant |=> stopGrantAck && state_q == LPSC_GRANT
			##1 (!stopGrantAck || !$past(clkEn));
	endproperty
	a_grantAck: assert property (p_grantAck) else $error("ack missing");

	property p_grantGates;
		@(posedge mclk) disable iff (!nrst)
		state_q == LPSC_GRANT |-> !coreClkEn && busClkEn && intCtrlClkEn && snoopEn && intrEn;
	endproperty
	a_grantGates: assert property (p_grantGates) else $error("grant gates wrong");

	property p_resume;
		@(posedge mclk) disable iff (!nrst)
		state_q == LPSC_GRANT && !stopReq && !sleepReq && clkEn |=> coreClkEn;
	endproperty
	a_resume: assert property (p_resume) else $error("no resume");
endmodule
`default_nettype wire

//--- lpsc_chipset.sv
`timescale 1ns/1ps
`default_nettype none

module lpsc_chipset
(
	input  wire logic       mclk,
	input  wire logic [3:0] cmd,
	output logic            clock_stop_request_n,
	output logic            sleep_request_n,
	output logic            deep_sleep_request_n,
	output logic            busClkPresent
);
	// pins move only off the sampling edge, as from an unrelated chipset clock
	initial
	begin
		{busClkPresent, deep_sleep_request_n, sleep_request_n, clock_stop_request_n} = 4'hf;
		forever
			@(negedge mclk)
				{busClkPresent, deep_sleep_request_n, sleep_request_n, clock_stop_request_n} <= cmd;
	end
endmodule

`default_nettype wire

//--- low_power_state_controller_tb.sv
`timescale 1ns/1ps
`default_nettype none

module low_power_state_controller_tb
	import lpsc_pkg::*;
;
	logic        mclk, nrst, clkEn, stopN, sleepN, deepN, busClk, refAck;
	logic [3:0]  cmd;
	logic [2:0]  p1, p2;
	logic [8:0]  refPrev, devPrev, dv;
	logic [31:0] r;
	logic [1:0]  powerState;
	logic [6:0]  g;
	lpsc_state_e refState;
	int          err_count, comparisons, seed;
	logic [8:0]  expQ[$];

	lpsc_chipset cs (.mclk(mclk), .cmd(cmd), .clock_stop_request_n(stopN),
		.sleep_request_n(sleepN), .deep_sleep_request_n(deepN), .busClkPresent(busClk));
	low_power_state_controller dut (.mclk(mclk), .nrst(nrst), .clkEn(clkEn),
		.clock_stop_request_n(stopN), .sleep_request_n(sleepN), .deep_sleep_request_n(deepN),
		.busClkPresent(busClk), .coreClkEn(g[6]), .busClkEn(g[5]), .intCtrlClkEn(g[4]),
		.pllEn(g[3]), .snoopEn(g[2]), .intrEn(g[1]), .stopGrantAck(g[0]),
		.powerState(powerState));

	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		$display("errors=%0d comparisons=%0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// gates {core,bus,intctrl,pll,snoop,intr} per state
	function automatic logic [8:0] vecOf(lpsc_state_e s, logic a);
		case (s)
			LPSC_RUN:   return {s, 6'h3f, a};
			LPSC_GRANT: return {s, 6'h1f, a};
			LPSC_SLEEP: return {s, 6'h04, a};
			default:    return {s, 6'h00, a};
		endcase
	endfunction

	// reference follows the pins through two sampling stages
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			p1       <= 3'h7;
			p2       <= 3'h7;
			refState <= LPSC_RUN;
			refAck   <= 1'h0;
		end
		else if (clkEn)
		begin
			p1     <= {deepN, sleepN, stopN};
			p2     <= p1;
			refAck <= 1'h0;
			case (refState)
				LPSC_RUN:
					if (!p2[0])
					begin
						refState <= LPSC_GRANT;
						refAck   <= 1'h1;
					end
				LPSC_GRANT:
					if (!p2[1])
						refState <= LPSC_SLEEP;
					else if (p2[0])
						refState <= LPSC_RUN;
				LPSC_SLEEP:
					if (p2[1])
						refState <= LPSC_GRANT;
					else if (!p2[2])
						refState <= LPSC_DEEP;
				default:
					if (p2[2] && busClk)
						refState <= LPSC_SLEEP;
			endcase
		end
	end

	// predicted output changes are noted for the watcher below
	always @(posedge mclk)
	begin
		#1;
		if (vecOf(refState, refAck) !== refPrev)
			expQ.push_back(vecOf(refState, refAck));
		refPrev = vecOf(refState, refAck);
	end

	// reset is watched too, so a mid-run reset must match the model
	always @(posedge mclk)
	begin
		#2;
		dv = {powerState, g};
		if (dv !== devPrev)
		begin
			if (expQ.size() == 0)
				check(dv, devPrev);
			else
				check(dv, expQ.pop_front());
		end
		devPrev = dv;
	end

	task automatic step(input logic [3:0] c, input int n);
		@(negedge mclk);
		cmd <= c;
		clkEn = 1'h1;
		repeat (n) @(negedge mclk);
	endtask

	always #4 mclk = ~mclk;

	initial
	begin
		#200000;
		err_count++;
		print_verdict();
	end

	initial
	begin
		{mclk, nrst, clkEn, cmd, seed} = {3'h1, 4'hf, 32'hc2980133};
		{refPrev, devPrev} = {9'h07e, 9'h07e};
		repeat (8) @(posedge mclk);
		@(negedge mclk);
		nrst = 1'h1;
		step(4'h9, 8);
		step(4'h8, 12);
		step(4'h0, 6);
		step(4'h4, 10);
		step(4'hc, 10);
		// reset while sleeping: back to run, then the held pins re-enter sleep
		nrst = 1'h0;
		repeat (2) @(negedge mclk);
		nrst = 1'h1;
		step(4'hc, 10);
		step(4'ha, 10);
		step(4'hf, 10);
		step(4'h8, 8);
		step(4'hd, 8);
		step(4'hf, 10);
		repeat (300)
		begin
			@(negedge mclk);
			r = $random(seed);
			cmd <= {1'h1, r[2:0]};
			clkEn = (r[5:3] != 3'h0);
			repeat (r[9:6]) @(negedge mclk);
		end
		step(4'hf, 20);
		check(9'(expQ.size()), 9'h000);
		print_verdict();
	end
endmodule

`default_nettype wire
